/* File: pkg/iwd_params.svh */
`ifndef IWD_PARAMS_SVH
`define IWD_PARAMS_SVH
`define IWD_WORD_W 14
`define IWD_FILE_W 7
`define IWD_BIT_W 3
`define IWD_LIT_W 8
`define IWD_ADDR_W 11
`define IWD_PHASES 4
`define IWD_OP_STANDBY 14'h0063
`define IWD_OP_WDT_RESTART 14'h0064
`define IWD_OP_ISR_RETURN 14'h0009
`define IWD_OP_SUB_RETURN 14'h0008
`define IWD_UPPER_ROTATE_LEFT 6'h0D
`define IWD_UPPER_ROTATE_RIGHT 6'h0C
`endif

/* File: pkg/iwd_pkg.sv */
package iwd_pkg;
  typedef enum logic [1:0] {
    IWD_CLASS_BYTE = 2'h0,
    IWD_CLASS_BIT = 2'h1,
    IWD_CLASS_LIT = 2'h2
  } iwd_class_t;
  typedef enum logic [1:0] {
    IWD_ST_EXEC = 2'h1,
    IWD_ST_FLUSH = 2'h2
  } iwd_state_t;
endpackage

/* File: rtl/iwd_decoder.sv */
`include "iwd_params.svh"
// Summary of operation
// [RQ1] Each decoded instruction is one 14-bit word with an opcode and operand fields.
// [RQ2] Each word is sorted into byte-oriented, bit-oriented or literal/control class.
// [RQ3] For byte operations a target bit of zero writes the accumulator and one writes the register.
// [RQ4] The register operand is a seven-bit direct address from 0x00 to 0x7F.
// [RQ5] For bit operations a three-bit field picks the bit of an 8-bit register.
// [RQ6] Literal operations carry an eight-bit constant, branches an eleven-bit target.
// [RQ7] Ignored opcode bits may be 0 or 1 without changing the decoded operation.
// [RQ8] Instructions take one cycle, or two when a test is true or the PC changes.
// [RQ9] One instruction cycle is four consecutive oscillator periods.
// [RQ10] The standby word 00 0000 0110 0011 takes one cycle and updates expiry and halt flags.
// [RQ11] The watchdog restart word 00 0000 0110 0100 takes one cycle and updates both flags.
// [RQ12] The interrupt return word 00 0000 0000 1001 takes two cycles.
// [RQ13] Rotate left uses upper bits 00 1101 and updates only the carry flag.
// [RQ14] On skip or redirect the prefetched word is discarded and a side-effect-free no-op runs.
module iwd_decoder (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [13:0] instr_i,
  input wire logic skip_true_i,
  output logic fetch_o,
  output logic cycle_start_o,
  output logic [1:0] instr_class_o,
  output logic [6:0] file_addr_o,
  output logic dest_file_o,
  output logic wr_accum_o,
  output logic wr_file_o,
  output logic [2:0] bit_sel_o,
  output logic [7:0] literal_o,
  output logic [10:0] target_o,
  output logic [5:0] byte_op_o,
  output logic [1:0] bit_op_o,
  output logic branch_o,
  output logic call_o,
  output logic return_o,
  output logic isr_return_op_o,
  output logic standby_op_o,
  output logic watchdog_restart_op_o,
  output logic rotate_left_op_o,
  output logic carry_only_o,
  output logic status_flags_upd_o,
  output logic nop_cycle_o
);
  logic [1:0] phase_reg, phase_next;
  iwd_pkg::iwd_state_t state_reg, state_next;
  logic [13:0] ir_reg, ir_next;

  function automatic logic iwd_match(input logic [13:0] w, input logic [13:0] pat);
    iwd_match = (w == pat);
  endfunction

  function automatic logic iwd_upper(input logic [13:0] w, input logic [5:0] pat);
    iwd_upper = (w[13:8] == pat);
  endfunction

  // [RQ1] [RQ2] Class from top bits
  logic [1:0] top;
  logic is_byte, is_bit, is_lit, is_goto_call, pc_change, bit_test;
  assign top = ir_reg[13:12];
  assign is_byte = (top == 2'h0);
  assign is_bit = (top == 2'h1);
  assign is_lit = top[1];
  assign is_goto_call = (top == 2'h2);
  assign bit_test = is_bit && ir_reg[11];

  logic op_ret, op_retlw, op_isr, op_stby, op_wdt, op_rlf, op_rrf, nop_now;

  // [RQ10] Standby decode
  assign op_stby = iwd_match(ir_reg, `IWD_OP_STANDBY);
  // [RQ11] Watchdog restart decode
  assign op_wdt = iwd_match(ir_reg, `IWD_OP_WDT_RESTART);
  // [RQ12] Interrupt return decode
  assign op_isr = iwd_match(ir_reg, `IWD_OP_ISR_RETURN);
  assign op_ret = iwd_match(ir_reg, `IWD_OP_SUB_RETURN);
  // [RQ7] Retlw ignores bits 9:8
  assign op_retlw = (ir_reg[13:10] == 4'hD);
  // [RQ13] Rotate left upper bits
  assign op_rlf = iwd_upper(ir_reg, `IWD_UPPER_ROTATE_LEFT);
  // [RQ13] Rotate right shares carry-only
  assign op_rrf = iwd_upper(ir_reg, `IWD_UPPER_ROTATE_RIGHT);
  // [RQ8] [RQ12] Program counter changes
  assign pc_change = is_goto_call || op_ret || op_retlw || op_isr;
  assign nop_now = (state_reg == iwd_pkg::IWD_ST_FLUSH);

  logic last_phase;
  // [RQ9] Four phases per cycle
  assign last_phase = (phase_reg == 2'(`IWD_PHASES - 1));

  always_comb begin
    phase_next = phase_reg + 2'h1;
    state_next = state_reg;
    ir_next = ir_reg;
    if (last_phase) begin
      case (state_reg)
        iwd_pkg::IWD_ST_EXEC: begin
          // [RQ14] Drop prefetched word
          if (pc_change || skip_true_i) begin
            state_next = iwd_pkg::IWD_ST_FLUSH;
            ir_next = 14'h0000;
          end else begin
            state_next = iwd_pkg::IWD_ST_EXEC;
            ir_next = instr_i;
          end
        end
        iwd_pkg::IWD_ST_FLUSH: begin
          state_next = iwd_pkg::IWD_ST_EXEC;
          ir_next = instr_i;
        end
        default: begin
          state_next = iwd_pkg::IWD_ST_FLUSH;
          ir_next = 14'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_reg <= 2'h0;
      state_reg <= iwd_pkg::IWD_ST_FLUSH;
      ir_reg <= 14'h0000;
    end else begin
      phase_reg <= phase_next;
      state_reg <= state_next;
      ir_reg <= ir_next;
    end
  end

  logic live;
  assign live = !nop_now;

  // [RQ9] Fetch strobe and cycle start
  assign fetch_o = last_phase;
  assign cycle_start_o = (phase_reg == 2'h0);

  // [RQ14] Forced no-op marker
  assign nop_cycle_o = nop_now;

  // [RQ4] Seven-bit file address
  assign file_addr_o = ir_reg[6:0];

  // [RQ5] Bit position field
  assign bit_sel_o = ir_reg[9:7];
  assign bit_op_o = ir_reg[11:10];

  // [RQ6] Literal and branch target
  assign literal_o = ir_reg[7:0];
  assign target_o = ir_reg[10:0];

  // [RQ3] Destination select bit
  assign dest_file_o = ir_reg[7];
  assign byte_op_o = ir_reg[13:8];

  // [RQ2] Class encoding
  always_comb begin
    case (top)
      2'h0: begin
        instr_class_o = iwd_pkg::IWD_CLASS_BYTE;
      end
      2'h1: begin
        instr_class_o = iwd_pkg::IWD_CLASS_BIT;
      end
      2'h2: begin
        instr_class_o = iwd_pkg::IWD_CLASS_LIT;
      end
      default: begin
        instr_class_o = iwd_pkg::IWD_CLASS_LIT;
      end
    endcase
  end

  // [RQ3] Destination routing, [RQ14] gated in no-op cycle
  always_comb begin
    wr_accum_o = 1'b0;
    wr_file_o = 1'b0;
    if (live) begin
      case (top)
        2'h0: begin
          if (ir_reg[11:8] == 4'h0) begin
            // Move to file only, control words keep bit 7 clear
            wr_file_o = ir_reg[7];
          end else begin
            wr_file_o = ir_reg[7];
            wr_accum_o = !ir_reg[7];
          end
        end
        2'h1: begin
          wr_file_o = !bit_test;
        end
        2'h3: begin
          wr_accum_o = 1'b1;
        end
        default: begin
          wr_accum_o = 1'b0;
          wr_file_o = 1'b0;
        end
      endcase
    end
  end

  // [RQ8] Goto and call
  assign branch_o = live && is_goto_call;
  assign call_o = live && is_goto_call && !ir_reg[11];

  // [RQ12] Subroutine, literal and interrupt returns
  assign return_o = live && (op_ret || op_retlw || op_isr);
  assign isr_return_op_o = live && op_isr;

  // [RQ10] Standby
  assign standby_op_o = live && op_stby;

  // [RQ11] Watchdog restart
  assign watchdog_restart_op_o = live && op_wdt;

  // [RQ13] Rotates touch carry only
  assign rotate_left_op_o = live && op_rlf;
  assign carry_only_o = live && (op_rlf || op_rrf);

  // [RQ10] [RQ11] Expiry and halt update
  assign status_flags_upd_o = live && (op_stby || op_wdt);
endmodule

/* File: sim/iwd_decoder_props.sv */
module iwd_decoder_props (
  input wire logic sys_clk_i, reset_i, skip_true_i, fetch_o, dest_file_o, wr_file_o, branch_o, nop_cycle_o,
  input wire logic status_flags_upd_o, watchdog_restart_op_o, input wire logic [13:0] instr_i,
  input wire logic [1:0] instr_class_o, input wire logic [6:0] file_addr_o);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  property p_gap; fetch_o |=> !fetch_o [*3] ##1 fetch_o; endproperty
  a_gap: assert property (p_gap) else $error("fetch gap");
  property p_cls; fetch_o && instr_i[13:12] == 2'h1 |=> nop_cycle_o || instr_class_o == 2'h1; endproperty
  a_cls: assert property (p_cls) else $error("class");
  property p_dst; fetch_o && instr_i[13:12] == 2'h0 ##1 !nop_cycle_o |-> dest_file_o == $past(instr_i[7]); endproperty
  a_dst: assert property (p_dst) else $error("dest");
  property p_adr; fetch_o && !instr_i[13] ##1 !nop_cycle_o |-> file_addr_o == $past(instr_i[6:0]); endproperty
  a_adr: assert property (p_adr) else $error("addr");
  property p_br; $rose(branch_o) |-> ##4 nop_cycle_o; endproperty
  a_br: assert property (p_br) else $error("branch");
  property p_skp; fetch_o && skip_true_i && !nop_cycle_o |=> nop_cycle_o [*4]; endproperty
  a_skp: assert property (p_skp) else $error("skip");
  property p_nop; nop_cycle_o |-> !wr_file_o && !status_flags_upd_o && !branch_o; endproperty
  a_nop: assert property (p_nop) else $error("nop");
  property p_wdt; fetch_o && instr_i == 14'h0064 ##1 !nop_cycle_o |-> watchdog_restart_op_o; endproperty
  a_wdt: assert property (p_wdt) else $error("wdt");
  c_br: cover property ($rose(branch_o));
  c_skp: cover property (fetch_o && skip_true_i);
  c_wdt: cover property (watchdog_restart_op_o);
endmodule
bind iwd_decoder iwd_decoder_props u_props (.*);

/* File: sim/iwd_prog_mem.sv */
module iwd_prog_mem (input wire logic sys_clk_i, fetch_i, skip_i, input wire logic [13:0] word_i,
  output logic [13:0] instr_o = 14'h0, output logic skip_o = 1'b0);
  always @(negedge sys_clk_i) begin
    instr_o <= fetch_i ? word_i : ~instr_o;
    skip_o <= fetch_i & skip_i;
  end
endmodule

/* File: sim/iwd_testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, s = 1'b0, skip_true_i, fetch_o, dest_file_o, wr_accum_o, wr_file_o;
  logic branch_o, isr_return_op_o, watchdog_restart_op_o, rotate_left_op_o, carry_only_o, status_flags_upd_o;
  logic nop_cycle_o, standby_op_o, call_o, return_o;
  logic [13:0] instr_i, w = 14'h0;
  logic [1:0] instr_class_o;
  logic [6:0] file_addr_o;
  logic [2:0] bit_sel_o;
  logic [7:0] literal_o;
  logic [10:0] target_o;
  int num_errors = 0, cmp_count = 0;
  iwd_decoder u_dut (.*, .byte_op_o(), .bit_op_o(), .cycle_start_o());
  iwd_prog_mem u_mem (.sys_clk_i, .fetch_i(fetch_o), .skip_i(s), .word_i(w), .instr_o(instr_i), .skip_o(skip_true_i));
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [13:0] got, input logic [13:0] exp);
    cmp_count++;
    if (got !== exp) num_errors++;
    if (got !== exp) $display("mismatch at %0t: %h vs %h", $time, got, exp);
  endtask
  task issue(input logic [13:0] word, input logic skip);
    {w, s} = {word, skip};
    repeat (8) if (fetch_o !== 1'b1) @(negedge sys_clk_i);
    if (fetch_o !== 1'b1) num_errors++;
    if (fetch_o !== 1'b1) end_sim;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask
  task t_all;
    issue(14'h0DA5, 1'b0);
    chk({instr_class_o, wr_file_o, wr_accum_o, file_addr_o, rotate_left_op_o, carry_only_o}, 14'h0497);
    issue(14'h17FF, 1'b0);
    chk({instr_class_o, bit_sel_o, file_addr_o}, 14'h07FF);
    issue(14'h33A5, 1'b0);
    chk({instr_class_o, literal_o}, 14'h02A5);
    issue(14'h2ABC, 1'b0);
    chk({branch_o, target_o}, 14'h0ABC);
    issue(14'h0063, 1'b0);
    issue(14'h0009, 1'b0);
    chk(isr_return_op_o, 14'h1);
    issue(14'h0064, 1'b0);
    chk({nop_cycle_o, watchdog_restart_op_o, wr_file_o}, 14'h4);
    issue(14'h0064, 1'b0);
    issue(14'h0B25, 1'b1);
    chk(nop_cycle_o, 14'h1);
    issue(14'h0063, 1'b0);
    chk({standby_op_o, status_flags_upd_o, wr_file_o, wr_accum_o}, 14'hC);
    issue(14'h017F, 1'b0);
    chk({wr_accum_o, wr_file_o, dest_file_o}, 14'h4);
    issue(14'h2005, 1'b0);
    chk({call_o, branch_o, return_o, target_o}, 14'h3005);
    issue(14'h0008, 1'b0);
    chk(nop_cycle_o, 14'h1);
    issue(14'h0008, 1'b0);
    chk({return_o, isr_return_op_o, wr_accum_o}, 14'h4);
    $display("t_all done");
  endtask
  initial begin
    repeat (4) @(negedge sys_clk_i);
    reset_i = 1'b0;
    t_all;
    end_sim;
  end
endmodule
